/* File: core/csc_regs.v */
// Clock source control registers: events, irq enables, run status,
// slow source selection with snapshot, calibration timer interval.
// Assumes AXI4-Lite master on clk_sys; task strobes come from outside.
//
// The AXI4-Lite interface to the registers was decided locally.
`include "csc_map.vh"

// Summary of operation
// - Write one to set register enables irq
// - Write one to clear register disables irq
// - Four enables: fast, slow, done, timeout
// - Timeout event register, software writable
// - Fast start task sets request flag
// - Slow start task sets request flag
// - Slow start captures source selection snapshot
// - Source field: RC, crystal, synthesized
// - Bypass bit selects rail-to-rail external clock
// - External bit replaces crystal; source must be crystal
// - Interval register survives ordinary reset
// - Interval in quarter seconds, 0.25 to 31.75
// - Done event records finished RC calibration
module csc_regs #(
  parameter QUARTER_CYC = `CSC_QUARTER_CYC
) (
  input wire clk_sys,
  input wire resetn,
  input wire retn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire fast_clock_start_task,
  input wire fast_clock_stop_task,
  input wire slow_clock_start_task,
  input wire slow_clock_stop_task,
  input wire cal_timer_start_task,
  input wire cal_timer_stop_task,
  input wire fast_clock_started,
  input wire slow_clock_started,
  input wire cal_done,
  input wire [31:0] fast_clock_state,
  input wire [31:0] slow_clock_state,
  output reg [1:0] slow_source_q,
  output reg slow_bypass_q,
  output reg slow_external_q,
  output reg irq_q
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [3:0] ien_q;
  reg [3:0] evt_q;
  reg fast_req_q;
  reg slow_req_q;
  reg [17:0] snap_q;
  reg [6:0] cal_iv_q;
  reg cal_run_q;
  reg [31:0] tick_cnt_q;
  reg [6:0] quarter_cnt_q;
  reg [11:0] awaddr_q;
  reg aw_have_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_have_q;
  wire timeout_pulse;
  wire [3:0] hw_set;
  wire do_wr;
  wire [31:0] wmask;
  wire [17:0] sel_cur;
  wire wr_ien_set;
  wire wr_ien_clr;
  wire wr_evt_done;
  wire wr_evt_cal_timeout;
  wire wr_sel;
  wire wr_iv;
  wire [3:0] irq_pend;
  wire quarter_end;
  wire [6:0] quarter_next;
  reg [31:0] rdata_d;
  reg [1:0] rresp_d;
  localparam [31:0] QUARTER_LAST = QUARTER_CYC - 1;

  // ----------------------------------------
  // Write channel: address and data in either order
  // ----------------------------------------
  assign do_wr = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign sel_cur = {slow_external_q, slow_bypass_q, 14'h0000, slow_source_q};

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Write decode, one strobe per register
  // ----------------------------------------
  // Unmapped offsets match nothing and are dropped
  assign wr_ien_set = do_wr && awaddr_q == `CSC_OFF_IEN_SET;
  assign wr_ien_clr = do_wr && awaddr_q == `CSC_OFF_IEN_CLR;
  assign wr_evt_done = do_wr && awaddr_q == `CSC_OFF_EVT_DONE;
  assign wr_evt_cal_timeout = do_wr && awaddr_q == `CSC_OFF_EVT_CAL_TIMEOUT;
  assign wr_sel = do_wr && awaddr_q == `CSC_OFF_SLOW_SEL;
  assign wr_iv = do_wr && awaddr_q == `CSC_OFF_CAL_IV;

  // ----------------------------------------
  // Enables, events, status
  // ----------------------------------------
  assign hw_set = {timeout_pulse, cal_done, slow_clock_started, fast_clock_started};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_evt
      // Only done and timeout are held here; started events stay pulses
      wire evt_wr;
      assign evt_wr = (gi == 2) ? wr_evt_done : (gi == 3) ? wr_evt_cal_timeout : 1'b0;
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          ien_q[gi] <= 1'b0;
          evt_q[gi] <= 1'b0;
        end else begin
          if (wr_ien_set && wmask[gi] && wdata_q[gi]) begin
            ien_q[gi] <= 1'b1;
          end else if (wr_ien_clr && wmask[gi] && wdata_q[gi]) begin
            ien_q[gi] <= 1'b0;
          end
          // Hardware set beats a software write in the same cycle
          if (gi >= 2 && hw_set[gi]) begin
            evt_q[gi] <= 1'b1;
          end else if (evt_wr && wmask[0]) begin
            evt_q[gi] <= wdata_q[0];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Interrupt, started events count only in their pulse cycle
  // ----------------------------------------
  assign irq_pend = ien_q & (evt_q | {2'b00, hw_set[1:0]});

  // Fast and slow started events live in another register block; only
  // their irq path is here, driven by the incoming event pulses.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_q <= 1'b0;
      fast_req_q <= 1'b0;
      slow_req_q <= 1'b0;
      snap_q <= `CSC_RST_SEL;
      slow_source_q <= `CSC_SRC_RC;
      slow_bypass_q <= 1'b0;
      slow_external_q <= 1'b0;
    end else begin
      irq_q <= |irq_pend;
      if (fast_clock_start_task) begin
        fast_req_q <= 1'b1;
      end else if (fast_clock_stop_task) begin
        fast_req_q <= 1'b0;
      end
      if (slow_clock_start_task) begin
        slow_req_q <= 1'b1;
        snap_q <= sel_cur;
      end else if (slow_clock_stop_task) begin
        slow_req_q <= 1'b0;
      end
      if (wr_sel) begin
        if (wstrb_q[0] && wdata_q[1:0] != 2'h3)
          slow_source_q <= wdata_q[1:0];
        if (wstrb_q[2]) begin
          slow_bypass_q <= wdata_q[`CSC_SEL_BYPASS];
          slow_external_q <= wdata_q[`CSC_SEL_EXT];
        end
      end
    end
  end

  // ----------------------------------------
  // Calibration timer, interval on retention reset only
  // ----------------------------------------
  always @(posedge clk_sys or negedge retn) begin
    if (!retn)
      cal_iv_q <= `CSC_RST_IV;
    else if (wr_iv && wstrb_q[0])
      cal_iv_q <= wdata_q[6:0];
  end

  assign quarter_end = tick_cnt_q == QUARTER_LAST;
  assign quarter_next = quarter_cnt_q + 7'h01;
  // Interval zero behaves as one quarter
  assign timeout_pulse = cal_run_q && quarter_end && quarter_next >= cal_iv_q;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cal_run_q <= 1'b0;
      tick_cnt_q <= 32'h00000000;
      quarter_cnt_q <= 7'h00;
    end else if (cal_timer_start_task) begin
      cal_run_q <= 1'b1;
      tick_cnt_q <= 32'h00000000;
      quarter_cnt_q <= 7'h00;
    end else if (cal_timer_stop_task || timeout_pulse) begin
      cal_run_q <= 1'b0;
    end else if (cal_run_q) begin
      if (quarter_end) begin
        tick_cnt_q <= 32'h00000000;
        quarter_cnt_q <= quarter_next;
      end else begin
        tick_cnt_q <= tick_cnt_q + 32'h00000001;
      end
    end
  end

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  always @* begin
    rdata_d = 32'h00000000;
    rresp_d = 2'h0;
    case (s_axi_araddr)
      `CSC_OFF_EVT_DONE: rdata_d = {31'h0, evt_q[`CSC_IEN_DONE]};
      `CSC_OFF_EVT_CAL_TIMEOUT: rdata_d = {31'h0, evt_q[`CSC_IEN_CAL_TIMEOUT]};
      `CSC_OFF_IEN_SET: rdata_d = {28'h0, ien_q};
      `CSC_OFF_IEN_CLR: rdata_d = {28'h0, ien_q};
      `CSC_OFF_FAST_REQ: rdata_d = {31'h0, fast_req_q};
      `CSC_OFF_FAST_STATE: rdata_d = fast_clock_state;
      `CSC_OFF_SLOW_REQ: rdata_d = {31'h0, slow_req_q};
      `CSC_OFF_SLOW_STATE: rdata_d = slow_clock_state;
      `CSC_OFF_SLOW_SNAP: rdata_d = {14'h0, snap_q};
      `CSC_OFF_SLOW_SEL: rdata_d = {14'h0, sel_cur};
      `CSC_OFF_CAL_IV: rdata_d = {25'h0, cal_iv_q};
      default: begin
        rdata_d = 32'h00000000;
        rresp_d = 2'h2;
      end
    endcase
  end

  // ----------------------------------------
  // Read channel, one cycle latency
  // ----------------------------------------
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= rresp_d;
        s_axi_rdata <= rdata_d;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* File: core/csc_map.vh */
// Register map constants for the clock source control register block.
// Assumes a 32-bit AXI4-Lite bus; offsets are byte addresses.
`ifndef CSC_MAP_VH
`define CSC_MAP_VH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define CSC_OFF_EVT_DONE 12'h10c
`define CSC_OFF_EVT_CAL_TIMEOUT 12'h110
`define CSC_OFF_IEN_SET 12'h304
`define CSC_OFF_IEN_CLR 12'h308
`define CSC_OFF_FAST_REQ 12'h408
`define CSC_OFF_FAST_STATE 12'h40c
`define CSC_OFF_SLOW_REQ 12'h414
`define CSC_OFF_SLOW_STATE 12'h418
`define CSC_OFF_SLOW_SNAP 12'h41c
`define CSC_OFF_SLOW_SEL 12'h518
`define CSC_OFF_CAL_IV 12'h538

// ----------------------------------------
// Fields
// ----------------------------------------
`define CSC_IEN_FAST 0
`define CSC_IEN_SLOW 1
`define CSC_IEN_DONE 2
`define CSC_IEN_CAL_TIMEOUT 3
`define CSC_SEL_SRC_LSB 0
`define CSC_SEL_BYPASS 16
`define CSC_SEL_EXT 17
`define CSC_SRC_RC 2'h0
`define CSC_SRC_XTAL 2'h1
`define CSC_SRC_SYNTH 2'h2
`define CSC_IV_W 7

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define CSC_RST_IEN 4'h0
`define CSC_RST_SEL 18'h00000
`define CSC_RST_IV 7'h01
`define CSC_QUARTER_S_NS 250000000
`define CSC_CLK_NS 10
`define CSC_QUARTER_CYC (`CSC_QUARTER_S_NS / `CSC_CLK_NS)

`endif

/* File: tb/csc_regs_assertions.sv */
// Checker for the clock source control registers.
// Bound to csc_regs from the testbench top; sees its ports only.
module csc_regs_assertions (
  input wire clk_sys,
  input wire resetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [1:0] slow_source_q,
  input wire slow_bypass_q,
  input wire slow_external_q,
  input wire irq_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Properties
  // ----
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_resp; s_wr_take |-> ##2 s_axi_bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write not answered");
  property p_rd_resp; s_rd_take |=> s_axi_rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read not answered");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready stuck");
  property p_src_legal; slow_source_q != 2'h3; endproperty
  a_src_legal: assert property (p_src_legal) else $error("bad source code");
  property p_out_reset;
    $rose(resetn) |-> slow_source_q == 2'h0 && !slow_bypass_q && !slow_external_q && !irq_q;
  endproperty
  a_out_reset: assert property (p_out_reset) else $error("outputs not reset");
  // Selection moves only as the tail of a bus write
  property p_sel_cause;
    !$stable({slow_source_q, slow_bypass_q, slow_external_q})
      |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2);
  endproperty
  a_sel_cause: assert property (p_sel_cause) else $error("selection moved alone");
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for csc_regs over AXI4-Lite.
// Assumes the design and its map header are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, resetn = 0, retn = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, slow_source_q;
  logic slow_bypass_q, slow_external_q, irq_q;
  logic [8:0] tk = 9'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] fast_clock_state = 32'h0, slow_clock_state = 32'h0;
  int n_mismatch = 0, tests_run = 0;
  // Rows: write address, write data, read address, expected word
  logic [87:0] rows [12] = '{
    {12'h304, 32'h5, 12'h304, 32'h5},
    {12'h304, 32'ha, 12'h304, 32'hf},
    {12'h304, 32'h0, 12'h308, 32'hf},
    {12'h308, 32'h3, 12'h304, 32'hc},
    {12'h304, 32'hfffffff0, 12'h308, 32'hc},
    {12'h308, 32'hffffffff, 12'h304, 32'h0},
    {12'h7f0, 32'h1, 12'h304, 32'h0},
    {12'h518, 32'h2, 12'h518, 32'h2},
    {12'h518, 32'h30001, 12'h518, 32'h30001},
    {12'h538, 32'h7f, 12'h538, 32'h7f},
    {12'h110, 32'h1, 12'h110, 32'h1},
    {12'h110, 32'h0, 12'h110, 32'h0}};

  // Short quarter so timer waits stay in tens of cycles
  csc_regs #(.QUARTER_CYC(4)) csc_regs_inst (
    .clk_sys, .resetn, .retn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .fast_clock_start_task(tk[0]), .fast_clock_stop_task(tk[1]),
    .slow_clock_start_task(tk[2]), .slow_clock_stop_task(tk[3]),
    .cal_timer_start_task(tk[4]), .cal_timer_stop_task(tk[5]),
    .fast_clock_started(tk[7]), .slow_clock_started(tk[8]), .cal_done(tk[6]),
    .fast_clock_state, .slow_clock_state, .slow_source_q,
    .slow_bypass_q, .slow_external_q, .irq_q);

  // ----
  // Tasks
  // ----
  task results;
    if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    @(posedge clk_sys);
  endtask
  // Holds rready low a cycle so the answer must stand
  task rd(input [11:0] a, input [31:0] e, input [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    @(posedge clk_sys);
    s_axi_rready <= 1;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge clk_sys);
  endtask
  task pulse(input int i);
    tk[i] <= 1;
    @(posedge clk_sys);
    tk <= 9'h0;
  endtask

  initial forever #5 clk_sys = ~clk_sys;
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    results;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    resetn <= 1;
    retn <= 1;
    @(posedge clk_sys);
    rd(12'h304, 32'h0, 2'h0);
    rd(12'h538, 32'h1, 2'h0);
    rd(12'h7fc, 32'h0, 2'h2);
    foreach (rows[i]) begin
      wr(rows[i][87:76], rows[i][75:44]);
      rd(rows[i][43:32], rows[i][31:0], 2'h0);
    end
    pulse(0);
    rd(12'h408, 32'h1, 2'h0);
    pulse(1);
    rd(12'h408, 32'h0, 2'h0);
    wr(12'h518, 32'h1);
    pulse(2);
    rd(12'h414, 32'h1, 2'h0);
    wr(12'h518, 32'h2);
    rd(12'h41c, 32'h1, 2'h0);
    wr(12'h518, 32'h3);
    rd(12'h518, 32'h2, 2'h0);
    pulse(3);
    rd(12'h414, 32'h0, 2'h0);
    fast_clock_state <= 32'h10001;
    slow_clock_state <= 32'h10002;
    rd(12'h40c, 32'h10001, 2'h0);
    rd(12'h418, 32'h10002, 2'h0);
    // Timeout after two quarters, eight cycles here
    wr(12'h538, 32'h2);
    wr(12'h304, 32'h8);
    pulse(4);
    repeat (4) @(posedge clk_sys);
    chk(irq_q, 32'h0);
    repeat (12) @(posedge clk_sys);
    chk(irq_q, 32'h1);
    rd(12'h110, 32'h1, 2'h0);
    wr(12'h110, 32'h0);
    @(posedge clk_sys);
    chk(irq_q, 32'h0);
    wr(12'h304, 32'h4);
    pulse(6);
    repeat (2) @(posedge clk_sys);
    chk(irq_q, 32'h1);
    rd(12'h10c, 32'h1, 2'h0);
    wr(12'h308, 32'h4);
    @(posedge clk_sys);
    chk(irq_q, 32'h0);
    wr(12'h304, 32'h1);
    pulse(7);
    @(posedge clk_sys);
    chk(irq_q, 32'h1);
    @(posedge clk_sys);
    chk(irq_q, 32'h0);
    pulse(8);
    repeat (2) @(posedge clk_sys);
    chk(irq_q, 32'h0);
    wr(12'h518, 32'h20001);
    chk({slow_external_q, slow_bypass_q, slow_source_q}, 32'h9);
    s_axi_wstrb <= 4'h1;
    wr(12'h518, 32'h10000);
    chk({slow_external_q, slow_bypass_q, slow_source_q}, 32'h8);
    s_axi_wstrb <= 4'hf;
    wr(12'h518, 32'h30001);
    chk({slow_external_q, slow_bypass_q, slow_source_q}, 32'hd);
    resetn <= 0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1;
    @(posedge clk_sys);
    chk({slow_external_q, slow_bypass_q, slow_source_q}, 32'h0);
    rd(12'h538, 32'h2, 2'h0);
    results;
  end
endmodule

bind csc_regs csc_regs_assertions csc_regs_assertions_inst (
  .clk_sys, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .slow_source_q, .slow_bypass_q, .slow_external_q,
  .irq_q);
